/* File: hw/acr_params.svh */
// constants for the converter result and trigger register block
// assumes an 8-bit register space reached over classic wishbone
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
`define ACR_OFF_RES_LO   8'h78
`define ACR_OFF_RES_HI   8'h79
`define ACR_OFF_CTRL_A   8'h7A
`define ACR_OFF_CTRL_B   8'h7B
`define ACR_OFF_CHSEL    8'h7C
`define ACR_OFF_DIS      8'h7E
`define ACR_OFF_CORE     8'h7F
`define ACR_BIT_EN       7
`define ACR_BIT_START    6
`define ACR_BIT_ATE      5
`define ACR_BIT_DONE     4
`define ACR_BIT_LAR      5
`define ACR_CTRL_B_MASK  8'h47
`define ACR_DIS_MASK     8'h3F
`define ACR_CHSEL_MASK   8'hEF
`define ACR_CTRL_A_MASK  8'hEF
`define ACR_TS_FREE      3'h0
`define ACR_ZERO8        8'h00
`define ACR_ZERO10       10'h000
`endif

/* File: hw/acr_pkg.sv */
// types shared by the converter result and trigger register block
// assumes acr_params.svh is available on the include path
package acr_pkg;
    typedef enum logic [1:0] {
        ACR_IDLE = 2'b00,
        ACR_BUSY = 2'b01
    } acr_state_e;
    typedef struct packed {
        logic       done;
        logic [9:0] value;
    } acr_core_s;
endpackage

/* File: hw/acr_regs.sv */
// register-side logic of a 10-bit converter: result bytes, trigger, pins
// assumes a classic wishbone master and a converter core outside
//
// Implementation choice: the Wishbone register port.
`include "acr_params.svh"

// Behaviour
// - right adjust puts bits 7:0 low
// - left adjust puts bits 9:2 high
// - load result at each conversion end unless low byte read locked it
// - low byte read locks until high read
// - control b reserved bits read zero
// - source select matters only when auto-triggering
// - rising source flag starts a conversion
// - select switch to set flag triggers
// - switching to free running never triggers
// - eight trigger source codes as listed
// - disable bits switch off pin buffers
// - disabled pin reads zero in port
// - disable register bits 7:6 read zero
// - inputs 6 and 7 have no disable
// - left adjust change shows at once
// - auto trigger enable is control a bit5
// - done flag sets, clears on vector/write-one
module acr_regs (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // wishbone slave
    input  wire logic       cyc_i,
    input  wire logic       stb_i,
    input  wire logic       we_i,
    input  wire logic [7:0] adr_i,
    input  wire logic [7:0] dat_i,
    output logic      [7:0] dat_o,
    output logic            ack_o,
    // converter core
    input  wire logic       core_done_i,
    input  wire logic [9:0] core_result_i,
    output logic            core_start_o,
    output logic            core_enable_o,
    // trigger sources 1..7, bit 0 unused
    input  wire logic [7:0] trig_flags_i,
    // interrupt vector taken
    input  wire logic       vector_taken_i,
    // analog pins digital side
    input  wire logic [5:0] pin_raw_i,
    output logic      [5:0] pin_value_o,
    output logic      [5:0] pin_buf_off_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]        ctrl_a_reg, ctrl_a_next;
    logic [7:0]        ctrl_b_reg, ctrl_b_next;
    logic [7:0]        chsel_reg, chsel_next;
    logic [7:0]        dis_reg, dis_next;
    logic [9:0]        res_reg, res_next;
    logic              lock_reg, lock_next;
    logic              trig_prev_reg, trig_prev_next;
    logic [7:0]        dat_reg, dat_next;
    logic              ack_reg, ack_next;
    logic              start_reg, start_next;
    logic [5:0]        pin_reg, pin_next;
    acr_pkg::acr_state_e state_reg, state_next;
    acr_pkg::acr_core_s  core_in;

    logic       acc;
    logic       wr;
    logic       rd;
    logic       trig_now;
    logic       trig_rise;
    logic       done_evt;
    logic [7:0] res_lo;
    logic [7:0] res_hi;

    // ------------------------------------------------------------
    // result presentation
    // ------------------------------------------------------------
    always_comb
    begin
        core_in.done  = core_done_i;
        core_in.value = core_result_i;
        if (chsel_reg[`ACR_BIT_LAR])
        begin
            res_hi = res_reg[9:2];
            res_lo = {res_reg[1:0], 6'h00};
        end
        else
        begin
            res_hi = {6'h00, res_reg[9:8]};
            res_lo = res_reg[7:0];
        end
    end

    // ------------------------------------------------------------
    // trigger selection
    // ------------------------------------------------------------
    always_comb
    begin
        trig_now = trig_flags_i[ctrl_b_reg[2:0]];
        if (ctrl_b_reg[2:0] == `ACR_TS_FREE)
        begin
            trig_now = 1'b0;
        end
        trig_rise = trig_now && !trig_prev_reg;
    end

    // ------------------------------------------------------------
    // bus and register next state
    // ------------------------------------------------------------
    always_comb
    begin
        acc            = cyc_i && stb_i && !ack_reg;
        wr             = acc && we_i;
        rd             = acc && !we_i;
        done_evt       = core_in.done && (state_reg == acr_pkg::ACR_BUSY);
        ctrl_a_next    = ctrl_a_reg;
        ctrl_b_next    = ctrl_b_reg;
        chsel_next     = chsel_reg;
        dis_next       = dis_reg;
        res_next       = res_reg;
        lock_next      = lock_reg;
        trig_prev_next = trig_now;
        dat_next       = dat_reg;
        ack_next       = acc;
        start_next     = 1'b0;
        state_next     = state_reg;
        if (vector_taken_i)
        begin
            ctrl_a_next[`ACR_BIT_DONE] = 1'b0;
        end
        if (wr)
        begin
            case (adr_i)
                `ACR_OFF_CTRL_A:
                begin
                    ctrl_a_next = (dat_i & `ACR_CTRL_A_MASK)
                                | (ctrl_a_reg & ~`ACR_CTRL_A_MASK);
                    if (dat_i[`ACR_BIT_DONE])
                    begin
                        ctrl_a_next[`ACR_BIT_DONE] = 1'b0;
                    end
                end
                `ACR_OFF_CTRL_B: ctrl_b_next = dat_i & `ACR_CTRL_B_MASK;
                `ACR_OFF_CHSEL:  chsel_next  = dat_i & `ACR_CHSEL_MASK;
                `ACR_OFF_DIS:    dis_next    = dat_i & `ACR_DIS_MASK;
                default:         ctrl_a_next = ctrl_a_next;
            endcase
        end
        if (rd)
        begin
            case (adr_i)
                `ACR_OFF_RES_LO:
                begin
                    dat_next  = res_lo;
                    lock_next = 1'b1;
                end
                `ACR_OFF_RES_HI:
                begin
                    dat_next  = res_hi;
                    lock_next = 1'b0;
                end
                `ACR_OFF_CTRL_A: dat_next = ctrl_a_reg;
                `ACR_OFF_CTRL_B: dat_next = ctrl_b_reg;
                `ACR_OFF_CHSEL:  dat_next = chsel_reg;
                `ACR_OFF_DIS:    dat_next = dis_reg;
                default:         dat_next = `ACR_ZERO8;
            endcase
        end
        // conversion sequencing
        case (state_reg)
            acr_pkg::ACR_IDLE:
            begin
                if (ctrl_a_reg[`ACR_BIT_EN] &&
                    (ctrl_a_reg[`ACR_BIT_START] ||
                     (ctrl_a_reg[`ACR_BIT_ATE] && trig_rise)))
                begin
                    start_next = 1'b1;
                    ctrl_a_next[`ACR_BIT_START] = 1'b1;
                    state_next = acr_pkg::ACR_BUSY;
                end
            end
            acr_pkg::ACR_BUSY:
            begin
                if (!ctrl_a_reg[`ACR_BIT_EN])
                begin
                    ctrl_a_next[`ACR_BIT_START] = 1'b0;
                    state_next = acr_pkg::ACR_IDLE;
                end
                else if (done_evt)
                begin
                    if (!lock_next)
                    begin
                        res_next = core_in.value;
                        ctrl_a_next[`ACR_BIT_DONE] = 1'b1;
                    end
                    ctrl_a_next[`ACR_BIT_START] = 1'b0;
                    state_next = acr_pkg::ACR_IDLE;
                end
            end
            default: state_next = acr_pkg::ACR_IDLE;
        endcase
        pin_next = pin_raw_i & ~dis_reg[5:0];
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_a_reg    <= `ACR_ZERO8;
            ctrl_b_reg    <= `ACR_ZERO8;
            chsel_reg     <= `ACR_ZERO8;
            dis_reg       <= `ACR_ZERO8;
            res_reg       <= `ACR_ZERO10;
            lock_reg      <= 1'b0;
            trig_prev_reg <= 1'b0;
            dat_reg       <= `ACR_ZERO8;
            ack_reg       <= 1'b0;
            start_reg     <= 1'b0;
            pin_reg       <= 6'h00;
            state_reg     <= acr_pkg::ACR_IDLE;
        end
        else
        begin
            ctrl_a_reg    <= ctrl_a_next;
            ctrl_b_reg    <= ctrl_b_next;
            chsel_reg     <= chsel_next;
            dis_reg       <= dis_next;
            res_reg       <= res_next;
            lock_reg      <= lock_next;
            trig_prev_reg <= trig_prev_next;
            dat_reg       <= dat_next;
            ack_reg       <= ack_next;
            start_reg     <= start_next;
            pin_reg       <= pin_next;
            state_reg     <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb
    begin
        dat_o         = dat_reg;
        ack_o         = ack_reg;
        core_start_o  = start_reg;
        core_enable_o = ctrl_a_reg[`ACR_BIT_EN];
        pin_value_o   = pin_reg;
        pin_buf_off_o = dis_reg[5:0];
    end
endmodule // acr_regs

/* File: testbench/acr_chk_props.sv */
// checker for acr_regs bus answers, trigger start and pin gating
// assumes it is bound onto acr_regs, one clock, sync reset
module acr_chk (
    // clock, reset and bus
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       we_i,
    input wire logic [7:0] adr_i,
    input wire logic [7:0] dat_i,
    input wire logic [7:0] dat_o,
    input wire logic       ack_o,
    // core and pins
    input wire logic       core_start_o,
    input wire logic       core_enable_o,
    input wire logic [5:0] pin_raw_i,
    input wire logic [5:0] pin_value_o,
    input wire logic [5:0] pin_buf_off_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---
    // properties
    // ---
    logic tk;
    logic wr_a;
    logic wr_d;
    assign tk = cyc_i && stb_i && !ack_o;
    assign wr_a = tk && we_i && adr_i == 8'h7A;
    assign wr_d = tk && we_i && adr_i == 8'h7E;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_rd(a); tk && !we_i && adr_i == a; endsequence
    sequence s_ack; ack_o ##1 !ack_o; endsequence
    property p_ack; tk |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("bad ack");
    property p_rb; s_rd(8'h7B) |=> (dat_o & 8'hB8) == 8'h00; endproperty
    a_rb: assert property (p_rb) else $error("ctrl b reserved");
    property p_rd; s_rd(8'h7E) |=> (dat_o & 8'hC0) == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("disable reserved");
    property p_pin;
        !$past(rst_i) |->
            pin_value_o == ($past(pin_raw_i) & ~$past(pin_buf_off_o));
    endproperty
    a_pin: assert property (p_pin) else $error("pin gating");
    property p_dis;
        !$past(rst_i) && $changed(pin_buf_off_o) |-> $past(wr_d)
            && {2'h0, pin_buf_off_o} == ($past(dat_i) & 8'h3F);
    endproperty
    a_dis: assert property (p_dis) else $error("disable bits");
    property p_en;
        !$past(rst_i) && $changed(core_enable_o) |-> $past(wr_a)
            && {core_enable_o, 7'h00} == ($past(dat_i) & 8'h80);
    endproperty
    a_en: assert property (p_en) else $error("enable bit");
    property p_sen; core_start_o |-> core_enable_o; endproperty
    a_sen: assert property (p_sen) else $error("start off");
    property p_s1; core_start_o |=> !core_start_o; endproperty
    a_s1: assert property (p_s1) else $error("start long");
endmodule // acr_chk

bind acr_regs acr_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .dat_i, .dat_o, .ack_o, .core_start_o, .core_enable_o,
    .pin_raw_i, .pin_value_o, .pin_buf_off_o);

/* File: testbench/tb_acr_regs.sv */
// bench for acr_regs: expected results worked out against the bus
// assumes acr_regs and its checker are compiled before it
module tb_acr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       cyc_i = 1'b0;
    logic       stb_i = 1'b0;
    logic       we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [7:0] dat_i = 8'h00;
    logic       core_done_i = 1'b0;
    logic [9:0] core_result_i = 10'h000;
    logic [7:0] trig_flags_i = 8'h00;
    logic       vector_taken_i = 1'b0;
    logic [5:0] pin_raw_i = 6'h00;
    logic [7:0] dat_o, rd;
    logic       ack_o, core_start_o, core_enable_o;
    logic [5:0] pin_value_o, pin_buf_off_o;
    int         n_errors = 0, num_checks = 0, n_starts = 0, ns = 0, v, c;
    logic [7:0] regs [7] = '{8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E};
    acr_regs uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i,
        .dat_o, .ack_o, .core_done_i, .core_result_i, .core_start_o,
        .core_enable_o, .trig_flags_i, .vector_taken_i, .pin_raw_i,
        .pin_value_o, .pin_buf_off_o);
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (core_start_o === 1'b1)
            n_starts <= n_starts + 1;
    // ---
    // tasks
    // ---
    task automatic chk(input logic [15:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, x);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, x};
        for (n = 0; n < 20 && ack_o !== 1'b1; n++)
            @(posedge clk_i);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        n_errors += int'(n == 20);
        if (n == 20)
            tally_and_finish();
    endtask
    task automatic rc(input logic [7:0] a, input int e);
        wb(1'b0, a, 8'h00);
        chk({8'h00, rd}, 16'(e));
    endtask
    task automatic conv(input int r);
        @(posedge clk_i);
        {core_done_i, core_result_i} <= {1'b1, 10'(r)};
        @(posedge clk_i);
        core_done_i <= 1'b0;
    endtask
    task automatic ck(input int e);
        repeat (4) @(posedge clk_i);
        chk(16'(n_starts), 16'(e));
    endtask
    // ---
    // stimulus
    // ---
    initial
    begin
        void'($urandom(32'h99654A0A));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (regs[i]) rc(regs[i], 0);
        wb(1'b1, 8'h7B, 8'h47);
        rc(8'h7B, 8'h47);
        wb(1'b1, 8'h7E, 8'h3F);
        rc(8'h7E, 8'h3F);
        repeat (4)
        begin
            c = $urandom & 8'h3F;
            wb(1'b1, 8'h7E, 8'(c));
            pin_raw_i <= 6'($urandom);
            repeat (2) @(posedge clk_i);
            chk(16'(pin_buf_off_o), 16'(c));
            chk(16'(pin_value_o), 16'(pin_raw_i & ~6'(c)));
        end
        v = $urandom & 16'h3FF;
        wb(1'b1, 8'h7A, 8'hC0);
        ns++;
        conv(v);
        ck(ns);
        rc(8'h7A, 8'h90);
        rc(8'h78, v & 8'hFF);
        rc(8'h79, v >> 8);
        vector_taken_i <= 1'b1;
        @(posedge clk_i);
        vector_taken_i <= 1'b0;
        rc(8'h7A, 8'h80);
        wb(1'b1, 8'h7C, 8'h20);
        rc(8'h79, v >> 2);
        rc(8'h78, (v & 3) << 6);
        wb(1'b1, 8'h7A, 8'hC0);
        ns++;
        conv(v ^ 16'h3FF);
        wb(1'b1, 8'h78, 8'hFF);
        rc(8'h7A, 8'h80);
        rc(8'h79, v >> 2);
        rc(8'h78, (v & 3) << 6);
        rc(8'h79, v >> 2);
        v = $urandom & 16'h3FF;
        wb(1'b1, 8'h7A, 8'hC0);
        ns++;
        conv(v);
        rc(8'h79, v >> 2);
        wb(1'b1, 8'h7A, 8'h90);
        rc(8'h7A, 8'h80);
        wb(1'b1, 8'h7A, 8'hA0);
        for (c = 1; c < 8; c++)
        begin
            wb(1'b1, 8'h7B, 8'(c));
            trig_flags_i <= 8'h01 << c;
            ns++;
            ck(ns);
            v = $urandom & 16'h3FF;
            conv(v);
            trig_flags_i <= 8'h00;
            rc(8'h79, v >> 2);
        end
        wb(1'b1, 8'h7B, 8'h02);
        trig_flags_i <= 8'h08;
        ck(ns);
        wb(1'b1, 8'h7B, 8'h03);
        ns++;
        ck(ns);
        conv(0);
        trig_flags_i <= 8'hFF;
        wb(1'b1, 8'h7B, 8'h00);
        ck(ns);
        wb(1'b1, 8'h7A, 8'h80);
        wb(1'b1, 8'h7B, 8'h01);
        ck(ns);
        tally_and_finish();
    end
endmodule // tb_acr_regs
